/* design/dtc_core.sv */
// converter control: alternate-register switching, overheat guard, write queue
// assumes a classic wishbone master on the system clock; pins synchronous except overheat
`timescale 1ns/1ps
module dtc_core (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // device pins
    input wire logic i_load_strobe_n,
    input wire logic i_queue_en_pin,
    input wire logic i_parallel_sel,
    input wire logic i_overheat_async,
    // outputs
    output logic [dtc_pkg::NUM_CH*dtc_pkg::DAT_W-1:0] o_dac_code,
    output logic o_amp_power_down,
    output logic o_queue_active,
    output logic o_irq
);
    import dtc_pkg::*;

    localparam int WR_WIN = WR_CYCLES;
    localparam int APPLY_WIN = APPLY_CYCLES;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic ack_q, init_done_q, queue_en_q, par_q, load_strobe_n_q;
    logic [31:0] dat_q;
    logic [DAT_W-1:0] ctrl_q;
    logic [EV_W-1:0] status_q, mask_q;
    logic irq_q, shut_q, hot_m_q, hot_q;
    logic [NUM_CH-1:0][DAT_W-1:0] reg_a_q, reg_b_q, out_q;
    logic [NUM_GRP-1:0] first_q;
    logic [NUM_CH-1:0] sel_b_q;
    logic [6:0] tick_cnt_q;
    logic was_busy_q;

    function automatic logic [2:0] grp_of(input logic [CODE_W-1:0] ch);
        grp_of = 3'(ch >> 3);
    endfunction

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire req = i_wb_cyc & i_wb_stb & ~ack_q;
    wire hit_wp = (i_wb_adr == ADR_WRITE_PORT);
    wire hit_ctrl = (i_wb_adr == ADR_CTRL);
    wire hit_st = (i_wb_adr == ADR_STATUS);
    wire hit_mask = (i_wb_adr == ADR_MASK);
    wire hit_state = (i_wb_adr == ADR_STATE);
    wire q_full, q_empty;
    wire [ENTRY_W-1:0] q_head;
    wire [QLVL_W-1:0] q_level;
    wire stall = req & i_wb_we & hit_wp & queue_en_q & q_full;
    wire ack_d = req & ~stall;
    wire wp_wr = ack_d & i_wb_we & hit_wp & (i_wb_sel[2:0] == 3'h7);
    wire mask_wr = ack_d & i_wb_we & hit_mask & i_wb_sel[0];
    wire st_rd = ack_d & ~i_wb_we & hit_st;

    // ----------------------------------------------------------------
    // write queue and apply pacing
    // ----------------------------------------------------------------
    wire tick = (tick_cnt_q == 7'(APPLY_CYCLES - 1));
    wire q_push = wp_wr & queue_en_q;
    wire q_pop = tick & ~q_empty & queue_en_q;
    wire ap_v = queue_en_q ? q_pop : wp_wr;
    wire [ENTRY_W-1:0] ap_e = queue_en_q ? q_head : i_wb_dat[ENTRY_W-1:0];
    wire [1:0] ap_sel = ap_e[SEL_LSB +: 2];
    wire [CODE_W-1:0] ap_code = ap_e[CODE_LSB +: CODE_W];
    wire [DAT_W-1:0] ap_dat = ap_e[DAT_LSB +: DAT_W];
    wire ap_ch_ok = (ap_code < CODE_W'(NUM_CH));
    wire [2:0] ap_grp = grp_of(ap_code);
    wire [NUM_GRP-1:0] grp_en = ctrl_q[CTRL_GRP_LSB +: NUM_GRP];
    wire ctrl_we = ap_v & (ap_sel == SEL_SPECIAL) & (ap_code == CODE_CTRL);
    wire soft_pu = ap_v & (ap_sel == SEL_SPECIAL) & (ap_code == CODE_SOFT_PU);
    wire a_we = ap_v & (ap_sel == SEL_A) & ap_ch_ok;
    wire b_we = ap_v & (ap_sel == SEL_B) & ap_ch_ok & grp_en[ap_grp];
    wire [NUM_GRP-1:0] new_grp_en = ap_dat[CTRL_GRP_LSB +: NUM_GRP];
    wire load_strobe_n_fall = load_strobe_n_q & ~i_load_strobe_n;
    wire guard_on = ctrl_q[CTRL_GUARD];
    wire trip = guard_on & hot_q & ~shut_q;
    wire drained = was_busy_q & q_empty & queue_en_q;
    wire [EV_W-1:0] ev_set = {drained, load_strobe_n_fall, trip};

    dtc_wr_queue u_queue (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_push(q_push),
        .i_data(i_wb_dat[ENTRY_W-1:0]),
        .o_full(q_full),
        .i_pop(q_pop),
        .o_data(q_head),
        .o_empty(q_empty),
        .o_level(q_level)
    );

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    wire [31:0] rd_word = hit_ctrl ? {18'h00000, ctrl_q} :
                          hit_st ? {29'h00000000, status_q} :
                          hit_mask ? {29'h00000000, mask_q} :
                          hit_state ? {16'h0000, 2'h0, q_level, 5'h00,
                                       par_q, queue_en_q, shut_q} :
                          32'h00000000;

    // ----------------------------------------------------------------
    // bus, init sampling, interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
            init_done_q <= 1'b0;
            queue_en_q <= 1'b0;
            par_q <= 1'b0;
            status_q <= '0;
            mask_q <= MASK_RST;
            irq_q <= 1'b0;
            load_strobe_n_q <= 1'b1;
            tick_cnt_q <= '0;
            was_busy_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
            if (ack_d) dat_q <= i_wb_we ? 32'h00000000 : rd_word;
            // pins caught once after release; later changes need a reset
            if (!init_done_q) begin
                init_done_q <= 1'b1;
                par_q <= i_parallel_sel;
                queue_en_q <= i_queue_en_pin & i_parallel_sel;
            end
            // a new event wins over the read that clears it
            status_q <= (status_q & ~(st_rd ? status_q : '0)) | ev_set;
            if (mask_wr) mask_q <= i_wb_dat[EV_W-1:0];
            irq_q <= |(((status_q & ~(st_rd ? status_q : '0)) | ev_set) & mask_q);
            load_strobe_n_q <= i_load_strobe_n;
            tick_cnt_q <= tick ? '0 : tick_cnt_q + 7'h01;
            was_busy_q <= ~q_empty;
        end
    end

    // ----------------------------------------------------------------
    // overheat guard
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            hot_m_q <= 1'b0;
            hot_q <= 1'b0;
            shut_q <= 1'b0;
        end else begin
            hot_m_q <= i_overheat_async;
            hot_q <= hot_m_q;
            if (!guard_on) shut_q <= 1'b0;
            else if (hot_q) shut_q <= 1'b1;
            else if (soft_pu) shut_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // control word, data registers and output switching
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_q <= CTRL_RST;
            reg_a_q <= '0;
            reg_b_q <= '0;
            out_q <= '0;
            first_q <= '1;
            sel_b_q <= '0;
        end else begin
            if (ctrl_we) ctrl_q <= ap_dat;
            if (a_we) reg_a_q[ap_code] <= ap_dat;
            if (b_we) reg_b_q[ap_code] <= ap_dat;
            // a group newly enabled restarts from A on its next strobe
            for (int g = 0; g < NUM_GRP; g++) begin
                if (ctrl_we && new_grp_en[g] && !grp_en[g]) first_q[g] <= 1'b1;
                else if (load_strobe_n_fall) first_q[g] <= 1'b0;
            end
            if (load_strobe_n_fall) begin
                for (int c = 0; c < NUM_CH; c++) begin
                    if (!grp_en[c / 8] || first_q[c / 8]) begin
                        sel_b_q[c] <= 1'b0;
                        out_q[c] <= reg_a_q[c];
                    end else begin
                        sel_b_q[c] <= ~sel_b_q[c];
                        out_q[c] <= sel_b_q[c] ? reg_a_q[c] : reg_b_q[c];
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_wb_ack = ack_q;
    assign o_wb_dat = dat_q;
    assign o_dac_code = out_q;
    assign o_amp_power_down = shut_q;
    assign o_queue_active = queue_en_q;
    assign o_irq = irq_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_strobe_grp0;
        load_strobe_n_fall && grp_en[0];
    endsequence

    sequence s_hot_seen;
        hot_q && guard_on;
    endsequence

    a_ctrl_decode: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        ctrl_we |=> ctrl_q == $past(ap_dat))
        else $error("control word not taken from special write");
    a_b_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        ap_v && ap_sel == SEL_B && ap_code == 6'h00 && !grp_en[0]
        |=> reg_b_q[0] == $past(reg_b_q[0]))
        else $error("B register written while mode disabled");
    a_first_from_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        s_strobe_grp0 and first_q[0] |=> out_q[0] == $past(reg_a_q[0]) && !sel_b_q[0])
        else $error("first strobe did not select A");
    a_swap_source: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        s_strobe_grp0 and !first_q[0] |=> sel_b_q[0] != $past(sel_b_q[0]))
        else $error("strobe did not swap source");
    a_off_uses_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        load_strobe_n_fall && !grp_en[0] |=> out_q[0] == $past(reg_a_q[0]))
        else $error("disabled group not updated from A");
    a_guard_off: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !guard_on |=> !shut_q)
        else $error("shutdown while guard disabled");
    a_trip_down: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        s_hot_seen |=> shut_q)
        else $error("hot die did not power down amplifiers");
    a_shut_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        shut_q && guard_on && !(soft_pu && !hot_q) |=> shut_q)
        else $error("shutdown released without cause");
    a_serial_noq: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !par_q |-> !queue_en_q && !q_push)
        else $error("queue active outside parallel mode");
    a_pin_fixed: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        init_done_q |=> $stable(queue_en_q) && $stable(par_q))
        else $error("queue enable changed without reset");
    a_wr_accept: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        req && i_wb_we && hit_wp && !q_full |-> ##[1:WR_WIN] ack_q)
        else $error("write not accepted within cycle time");
    a_drain_pace: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        q_pop ##1 !q_empty |-> ##[1:APPLY_WIN] q_pop)
        else $error("queue drain too slow");
    a_sync_trip: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        $rose(shut_q) |-> $past(hot_q) && $past(hot_m_q, 2))
        else $error("shutdown without synchronised overheat");

    // last entry leaves with nothing arriving, so the drained event must follow
    sequence s_last_pop;
        q_pop && !q_push && q_level == 6'h01;
    endsequence

    a_a_load: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        a_we && ap_code == 6'h08 |=> reg_a_q[8] == $past(ap_dat))
        else $error("A register write lost");
    a_b_load: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        b_we && ap_code == 6'h00 |=> reg_b_q[0] == $past(ap_dat))
        else $error("B register write lost while mode enabled");
    a_first_rearm: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        ctrl_we && new_grp_en[0] && !grp_en[0] |=> first_q[0])
        else $error("enabling a group did not re-arm the first strobe");
    a_trip_event: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        trip |=> status_q[EV_TRIP])
        else $error("thermal trip not recorded");
    a_soft_pu_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        shut_q && guard_on && soft_pu && !hot_q |=> !shut_q)
        else $error("soft power-up while cool did not restore amplifiers");
    a_first_pop: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        q_push && q_empty |-> ##[1:APPLY_WIN] q_pop)
        else $error("queued write not applied within one slot");
    a_drain_event: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        s_last_pop |=> ##1 status_q[EV_DRAINED])
        else $error("queue drain not recorded");
endmodule // dtc_core

/* design/dtc_pkg.sv */
// constants shared by the converter control block and its write queue
// assumes a single 125 MHz system clock and a 32-bit classic wishbone slave port
package dtc_pkg;
    // ----------------------------------------------------------------
    // channel and word layout
    // ----------------------------------------------------------------
    localparam int NUM_CH = 40;
    localparam int NUM_GRP = 5;
    localparam int DAT_W = 14;
    localparam int CODE_W = 6;
    localparam int ENTRY_W = 22;
    localparam int DAT_LSB = 0;
    localparam int CODE_LSB = 14;
    localparam int SEL_LSB = 20;
    localparam logic [1:0] SEL_SPECIAL = 2'h0;
    localparam logic [1:0] SEL_B = 2'h2;
    localparam logic [1:0] SEL_A = 2'h3;
    localparam logic [5:0] CODE_CTRL = 6'h0C;
    localparam logic [5:0] CODE_SOFT_PU = 6'h09;
    localparam int CTRL_GRP_LSB = 2;
    localparam int CTRL_GUARD = 8;
    localparam logic [13:0] CTRL_RST = 14'h0000;
    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADR_WRITE_PORT = 8'h00;
    localparam logic [7:0] ADR_CTRL = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;
    localparam logic [7:0] ADR_MASK = 8'h0C;
    localparam logic [7:0] ADR_STATE = 8'h10;
    localparam int EV_W = 3;
    localparam int EV_TRIP = 0;
    localparam int EV_STROBE = 1;
    localparam int EV_DRAINED = 2;
    localparam logic [2:0] MASK_RST = 3'h0;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int WR_CYCLE_NS = 40;
    localparam int WR_CYCLES = (WR_CYCLE_NS * CLK_MHZ) / 1000;
    localparam int UPDATE_ALL_NS = 14400;
    localparam int APPLY_CYCLES = ((UPDATE_ALL_NS * CLK_MHZ) / 1000) / NUM_CH;
    localparam int QDEPTH = NUM_CH;
    localparam int QLVL_W = 6;
endpackage

/* design/dtc_wr_queue.sv */
// write queue holding one full set of channel writes
// assumes push is never given while full and pop never while empty
`timescale 1ns/1ps
module dtc_wr_queue (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // fill side
    input wire logic i_push,
    input wire logic [dtc_pkg::ENTRY_W-1:0] i_data,
    output logic o_full,
    // drain side
    input wire logic i_pop,
    output logic [dtc_pkg::ENTRY_W-1:0] o_data,
    output logic o_empty,
    output logic [dtc_pkg::QLVL_W-1:0] o_level
);
    import dtc_pkg::*;

    logic [ENTRY_W-1:0] mem_q [QDEPTH];
    logic [QLVL_W-1:0] wp_q, rp_q, lvl_q;

    function automatic logic [QLVL_W-1:0] bump(input logic [QLVL_W-1:0] p);
        bump = (p == QLVL_W'(QDEPTH - 1)) ? '0 : p + 6'h01;
    endfunction

    assign o_full = (lvl_q == QLVL_W'(QDEPTH));
    assign o_empty = (lvl_q == 6'h00);
    assign o_data = mem_q[rp_q];
    assign o_level = lvl_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_push) begin
            mem_q[wp_q] <= i_data;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            wp_q <= '0;
            rp_q <= '0;
            lvl_q <= '0;
        end else begin
            if (i_push) wp_q <= bump(wp_q);
            if (i_pop) rp_q <= bump(rp_q);
            lvl_q <= lvl_q + QLVL_W'(i_push) - QLVL_W'(i_pop);
        end
    end
endmodule // dtc_wr_queue

/* tb/dtc_host_model.sv */
// host-side partner: drives the active-low load strobe and the overheat sensor level
// assumes one-cycle pulse requests from the bench on the system clock
`timescale 1ns/1ps
module dtc_host_model (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // bench requests
    input wire logic i_pulse,
    input wire logic i_hot,
    // pins toward the block
    output logic o_load_strobe_n,
    output logic o_overheat_async
);
    // ----------------------------------------------------------------
    // load strobe: low for two cycles, then high for at least three before another
    // ----------------------------------------------------------------
    logic [2:0] cnt_q;
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= 3'h0;
        end else if (i_pulse && cnt_q == 3'h0) begin
            cnt_q <= 3'h4;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end
    end
    // strobe rate is set by the bench; the counter fixes the two-cycle low time and ignores pulses until three high cycles pass
    assign o_load_strobe_n = !(cnt_q > 3'h2);
    // ----------------------------------------------------------------
    // sensor: level passed straight through from the bench
    // ----------------------------------------------------------------
    // the bench moves it on a clock edge; the block still spends two flops on it
    assign o_overheat_async = i_hot;
endmodule // dtc_host_model

/* tb/test_dtc_core.sv */
// self-checking bench for the converter control block
// assumes direct mode unless reset with queue pin and parallel select both high
`timescale 1ns/1ps
module test_dtc_core;
    import dtc_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic ack, ldn, hot_a, qen = 1'b0, par = 1'b0, pulse = 1'b0, hot = 1'b0;
    logic pd, qact, irq;
    logic [NUM_CH*DAT_W-1:0] dac;
    int n_fail = 0, cmp_count = 0, cnt = 0, t0;
    initial forever #4 clk = ~clk;
    always @(posedge clk) cnt <= cnt + 1;
    dtc_core DUT (.i_clk_sys(clk), .i_rstn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_load_strobe_n(ldn), .i_queue_en_pin(qen), .i_parallel_sel(par),
        .i_overheat_async(hot_a), .o_dac_code(dac), .o_amp_power_down(pd),
        .o_queue_active(qact), .o_irq(irq));
    dtc_host_model host (.i_clk_sys(clk), .i_rstn(rstn), .i_pulse(pulse), .i_hot(hot),
        .o_load_strobe_n(ldn), .o_overheat_async(hot_a));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // classic cycle: hold everything until ack is sampled high at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 200);
        if (ack !== 1'b1) n_fail++;
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    function automatic logic [31:0] wp(logic [1:0] s, logic [5:0] c, logic [13:0] d);
        return {10'h000, s, c, d};
    endfunction
    function automatic logic [31:0] ch(int c);
        return {18'h00000, dac[c*DAT_W +: DAT_W]};
    endfunction
    task automatic strobe;
        @(posedge clk) pulse <= 1'b1;
        @(posedge clk) pulse <= 1'b0;
        repeat (10) @(posedge clk);
    endtask
    task automatic do_reset(input logic qe, input logic pa);
        @(posedge clk) rstn <= 1'b0;
        qen <= qe; par <= pa;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        #480000;
        n_fail++;
        report_and_stop;
    end
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        do_reset(1'b0, 1'b0);
        wb(1'b0, ADR_CTRL, 0); chk(q, 32'h0);
        wb(1'b0, ADR_MASK, 0); chk(q, 32'h0);
        wb(1'b0, 8'h14, 0); chk(q, 32'h0);
        chk({qact, pd, irq}, 32'h0);
        $display("test reset done");
        // enable group 0, load A then B, then strobe
        wb(1'b1, ADR_WRITE_PORT, wp(SEL_SPECIAL, CODE_CTRL, 14'h0004));
        wb(1'b0, ADR_CTRL, 0); chk(q, 32'h4);
        wb(1'b1, ADR_WRITE_PORT, wp(SEL_A, 6'h00, 14'h0111));
        wb(1'b1, ADR_WRITE_PORT, wp(SEL_A, 6'h08, 14'h0222));
        wb(1'b1, ADR_WRITE_PORT, wp(SEL_B, 6'h00, 14'h0333));
        wb(1'b1, ADR_WRITE_PORT, wp(SEL_B, 6'h08, 14'h0444));
        strobe; chk(ch(0), 32'h111); chk(ch(8), 32'h222);
        strobe; chk(ch(0), 32'h333); chk(ch(8), 32'h222);
        strobe; chk(ch(0), 32'h111);
        wb(1'b1, ADR_WRITE_PORT, wp(SEL_SPECIAL, CODE_CTRL, 14'h0000));
        strobe; chk(ch(0), 32'h111);
        wb(1'b1, ADR_WRITE_PORT, wp(SEL_B, 6'h00, 14'h0AAA));
        strobe; chk(ch(0), 32'h111);
        wb(1'b1, ADR_WRITE_PORT, wp(SEL_SPECIAL, CODE_CTRL, 14'h0004));
        strobe; chk(ch(0), 32'h111);
        strobe; chk(ch(0), 32'h333);
        $display("test alternate done");
        // strobe event through status and mask
        wb(1'b0, ADR_STATUS, 0);
        wb(1'b1, ADR_MASK, 32'h2);
        wb(1'b0, ADR_MASK, 0); chk(q, 32'h2);
        strobe; chk(irq, 1'b1);
        wb(1'b0, ADR_STATUS, 0); chk(q & 32'h2, 32'h2);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        wb(1'b1, ADR_MASK, 32'h0);
        strobe; chk(irq, 1'b0);
        $display("test irq done");
        // overheat guard and both recovery paths
        hot <= 1'b1;
        repeat (10) @(posedge clk);
        chk(pd, 1'b0);
        wb(1'b1, ADR_WRITE_PORT, wp(SEL_SPECIAL, CODE_CTRL, 14'h0100));
        repeat (6) @(posedge clk);
        chk(pd, 1'b1);
        wb(1'b1, ADR_WRITE_PORT, wp(SEL_SPECIAL, CODE_SOFT_PU, 14'h0000));
        repeat (6) @(posedge clk);
        chk(pd, 1'b1);
        hot <= 1'b0;
        repeat (6) @(posedge clk);
        chk(pd, 1'b1);
        wb(1'b1, ADR_WRITE_PORT, wp(SEL_SPECIAL, CODE_SOFT_PU, 14'h0000));
        repeat (2) @(posedge clk);
        chk(pd, 1'b0);
        hot <= 1'b1;
        repeat (6) @(posedge clk);
        chk(pd, 1'b1);
        wb(1'b0, ADR_STATUS, 0); chk(q & 32'h1, 32'h1);
        wb(1'b1, ADR_WRITE_PORT, wp(SEL_SPECIAL, CODE_CTRL, 14'h0000));
        repeat (2) @(posedge clk);
        chk(pd, 1'b0);
        hot <= 1'b0;
        $display("test thermal done");
        // queue only with parallel select; pin latched at reset
        do_reset(1'b1, 1'b0); chk(qact, 1'b0);
        do_reset(1'b1, 1'b1); chk(qact, 1'b1);
        qen <= 1'b0;
        repeat (4) @(posedge clk);
        chk(qact, 1'b1);
        wb(1'b0, ADR_STATUS, 0);
        t0 = cnt;
        for (int c = 0; c < NUM_CH; c++) begin
            wb(1'b1, ADR_WRITE_PORT, wp(SEL_A, 6'(c), 14'(14'h1000 + c)));
        end
        chk(32'(cnt - t0 <= NUM_CH * WR_CYCLES), 32'h1);
        // queued entries land in the A registers; the outputs follow only on a strobe
        do begin
            wb(1'b0, ADR_STATE, 0);
        end while (q[13:8] !== 6'h00 && cnt - t0 < 2200);
        chk(32'(cnt - t0 <= (UPDATE_ALL_NS * CLK_MHZ) / 1000 + 8), 32'h1);
        chk(q & 32'h6, 32'h6);
        strobe;
        for (int c = 0; c < NUM_CH; c++) chk(ch(c), 32'h1000 + c);
        repeat (4) @(posedge clk);
        wb(1'b0, ADR_STATUS, 0); chk(q & 32'h4, 32'h4);
        $display("test queue done");
        report_and_stop;
    end
endmodule // test_dtc_core
